// File: design/fsp_defs.svh
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// register offsets, byte addresses on the apb bus
`define FSP_OFF_CTRL 8'h00
`define FSP_OFF_KEY 8'h04
`define FSP_OFF_TBLPAGE 8'h08
`define FSP_OFF_TBLEA 8'h0c
`define FSP_OFF_LATCH 8'h10
`define FSP_OFF_VISPAGE 8'h14
`define FSP_OFF_VISEA 8'h18
`define FSP_OFF_VISADDR 8'h1c
`define FSP_OFF_STATUS 8'h20
`define FSP_OFF_MASK 8'h24

// control register field positions
`define FSP_CTRL_SIZE_LO 0
`define FSP_CTRL_SIZE_HI 1
`define FSP_CTRL_PROG 4
`define FSP_CTRL_MEM 6
`define FSP_CTRL_START 15

// status and mask bit of the completion flag
`define FSP_STAT_DONE 15

// erase size codes
`define FSP_ERASE_1ROW 2'h0
`define FSP_ERASE_2ROW 2'h1
`define FSP_ERASE_4ROW 2'h2

// unlock key values, taken from the low byte
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa

// the only legal visibility page values
`define FSP_VIS_FLASH 8'h00
`define FSP_VIS_EEPROM 8'hff

// reset values
`define FSP_LATCH_RST 24'hffffff
`define FSP_PAGE_RST 8'h00

`endif

// File: design/fsp_pkg.sv
package fsp_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_prog,
        st_erase,
        st_wait
    } fsp_state_type;

    // unlock key progress
    typedef enum logic [1:0] {
        key_idle,
        key_half,
        key_armed
    } fsp_key_type;

endpackage

// File: design/fsp_ctrl.sv
// Function
// - flash rows hold 32 instruction words
// - erase one, two or four rows; program one
// - erase and write blocks aligned to own size
// - table writes fill latches, not the array
// - program succeeds however many latch writes preceded
// - latches load any order, later write replaces
// - latch write completes in two cycles
// - one programming cycle writes one row only
// - control selects erase size, memory, start
// - unlock key register is write only
// - start honoured only after 55h then aah
// - start bit launches, cleared by hardware
// - processor stalls while operation runs
// - visibility address bit 15 from page bit 0
// - visibility page takes only 00 or ff
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "fsp_defs.svh"

module fsp_ctrl #(
    parameter int ROW_WORDS = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic cpu_stall,
    output logic flash_prog_we,
    output logic flash_erase_req,
    output logic [1:0] flash_erase_size,
    output logic flash_mem_sel,
    output logic [23:0] flash_addr,
    output logic [23:0] flash_wdata,
    input wire logic flash_done
);

    // index width inside a row and row number width
    localparam int IW = $clog2(ROW_WORDS);
    localparam int RW = 23 - IW;

    // the row and address arithmetic needs a power of two row
    if (ROW_WORDS < 2 || ROW_WORDS > 64 || (1 << IW) != ROW_WORDS) begin : g_bad_row
        $error("fsp_ctrl: ROW_WORDS must be a power of two from 2 to 64");
    end

    // row holding latches
    logic [23:0] latch [ROW_WORDS];
    // control fields
    logic [1:0] ctrl_size;
    logic ctrl_prog;
    logic ctrl_mem;
    logic ctrl_start;
    // table pointer and visibility window
    logic [7:0] table_page;
    logic [15:0] table_ea;
    logic [7:0] vis_page;
    logic [15:0] vis_ea;
    // completion flag and its mask
    logic flag;
    logic mask;
    // sequencer
    fsp_pkg::fsp_state_type state;
    fsp_pkg::fsp_key_type key_stage;
    logic [IW-1:0] word_idx;

    // apb phase decode
    wire busy = (state != fsp_pkg::st_idle);
    wire take = psel & penable & pready;
    wire wr_take = take & pwrite;
    wire sel_ctrl = (paddr == `FSP_OFF_CTRL);
    wire sel_key = (paddr == `FSP_OFF_KEY);
    wire sel_tpg = (paddr == `FSP_OFF_TBLPAGE);
    wire sel_tea = (paddr == `FSP_OFF_TBLEA);
    wire sel_lat = (paddr == `FSP_OFF_LATCH);
    wire sel_vpg = (paddr == `FSP_OFF_VISPAGE);
    wire sel_vea = (paddr == `FSP_OFF_VISEA);
    wire sel_vad = (paddr == `FSP_OFF_VISADDR);
    wire sel_stat = (paddr == `FSP_OFF_STATUS);
    wire sel_mask = (paddr == `FSP_OFF_MASK);
    wire mapped = sel_ctrl | sel_key | sel_tpg | sel_tea | sel_lat | sel_vpg | sel_vea | sel_vad | sel_stat | sel_mask;

    // per register write strobes
    wire wr_ctrl = wr_take & sel_ctrl;
    wire wr_key = wr_take & sel_key;
    wire wr_lat = wr_take & sel_lat;
    wire wr_vpg = wr_take & sel_vpg;
    wire wr_stat = wr_take & sel_stat;

    // table pointer into program space
    wire [23:0] tbl_addr = {table_page, table_ea};
    wire [IW-1:0] lat_idx = tbl_addr[IW:1];
    wire [RW-1:0] row_base = tbl_addr[23:IW+1];

    // erase block alignment mask in rows
    wire [RW-1:0] size_mask = (ctrl_size == `FSP_ERASE_1ROW) ? RW'(0) :
                              (ctrl_size == `FSP_ERASE_2ROW) ? RW'(1) : RW'(3);
    wire [RW-1:0] erase_row = row_base & ~size_mask;

    // visibility translation, ea bit 15 dropped
    wire [23:0] vis_addr = {1'b0, vis_page, vis_ea[14:0]};

    // key sequence and start decisions
    wire key_lo55 = (pwdata[7:0] == `FSP_KEY_FIRST);
    wire key_loaa = (pwdata[7:0] == `FSP_KEY_SECOND);
    wire launch = wr_ctrl & pwdata[`FSP_CTRL_START] & (key_stage == fsp_pkg::key_armed) & ~busy;
    wire vis_ok = (pwdata[7:0] == `FSP_VIS_FLASH) | (pwdata[7:0] == `FSP_VIS_EEPROM);

    // completion event and flag update, set beats clear
    wire done_evt = (state == fsp_pkg::st_wait) & flash_done;
    wire next_flag = done_evt | (flag & ~(wr_stat & pwdata[`FSP_STAT_DONE]));

    // read data selection
    wire [31:0] ctrl_word = {16'h0000, ctrl_start, 8'h00, ctrl_mem, 1'b0, ctrl_prog, 2'b00, ctrl_size};
    wire [31:0] rd_data =
        sel_ctrl ? ctrl_word :
        sel_tpg ? {24'h000000, table_page} :
        sel_tea ? {16'h0000, table_ea} :
        sel_lat ? {8'h00, latch[lat_idx]} :
        sel_vpg ? {24'h000000, vis_page} :
        sel_vea ? {16'h0000, vis_ea} :
        sel_vad ? {8'h00, vis_addr} :
        sel_stat ? {16'h0000, flag, 15'h0000} :
        sel_mask ? {16'h0000, mask, 15'h0000} : 32'h00000000;

    // answer in the first access cycle unless the core is stalled
    wire next_pready = psel & ~pready & ~busy;

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_pready ? rd_data : 32'h00000000;
            pslverr <= next_pready & ~mapped;
        end
    end

    // holding latches, one write port per entry
    for (genvar i = 0; i < ROW_WORDS; i++) begin : g_latch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                latch[i] <= `FSP_LATCH_RST;
            end else if (wr_lat && lat_idx == IW'(i)) begin
                latch[i] <= pwdata[23:0];
            end
        end
    end

    // unlock key tracker, any other write breaks the pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_stage <= fsp_pkg::key_idle;
        end else if (wr_key && key_lo55) begin
            key_stage <= fsp_pkg::key_half;
        end else if (wr_key && key_loaa && key_stage == fsp_pkg::key_half) begin
            key_stage <= fsp_pkg::key_armed;
        end else if (wr_take) begin
            key_stage <= fsp_pkg::key_idle;
        end
    end

    // pointer, window and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_page <= `FSP_PAGE_RST;
            table_ea <= 16'h0000;
            vis_page <= `FSP_PAGE_RST;
            vis_ea <= 16'h0000;
            mask <= 1'b0;
        end else begin
            if (wr_take && sel_tpg) begin
                table_page <= pwdata[7:0];
            end
            if (wr_take && sel_tea) begin
                table_ea <= pwdata[15:0];
            end
            // other page values are dropped
            if (wr_vpg && vis_ok) begin
                vis_page <= pwdata[7:0];
            end
            if (wr_take && sel_vea) begin
                vis_ea <= pwdata[15:0];
            end
            if (wr_take && sel_mask) begin
                mask <= pwdata[`FSP_STAT_DONE];
            end
        end
    end

    // flag and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            flag <= next_flag;
            irq <= next_flag & mask;
        end
    end

    // control fields, written only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_size <= `FSP_ERASE_1ROW;
            ctrl_prog <= 1'b0;
            ctrl_mem <= 1'b0;
        end else if (wr_ctrl && !busy) begin
            ctrl_size <= pwdata[`FSP_CTRL_SIZE_HI:`FSP_CTRL_SIZE_LO];
            ctrl_prog <= pwdata[`FSP_CTRL_PROG];
            ctrl_mem <= pwdata[`FSP_CTRL_MEM];
        end
    end

    // sequencer: stream one row or issue one erase, then wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= fsp_pkg::st_idle;
            ctrl_start <= 1'b0;
            cpu_stall <= 1'b0;
            word_idx <= '0;
            flash_prog_we <= 1'b0;
            flash_erase_req <= 1'b0;
            flash_erase_size <= `FSP_ERASE_1ROW;
            flash_mem_sel <= 1'b0;
            flash_addr <= 24'h000000;
            flash_wdata <= 24'h000000;
        end else begin
            case (state)
                fsp_pkg::st_idle: begin
                    // keyless start leaves the sequencer idle; the control fields still take the write
                    if (launch) begin
                        ctrl_start <= 1'b1;
                        cpu_stall <= 1'b1;
                        word_idx <= '0;
                        flash_mem_sel <= pwdata[`FSP_CTRL_MEM];
                        flash_erase_size <= pwdata[`FSP_CTRL_SIZE_HI:`FSP_CTRL_SIZE_LO];
                        state <= pwdata[`FSP_CTRL_PROG] ? fsp_pkg::st_prog : fsp_pkg::st_erase;
                    end
                end
                fsp_pkg::st_prog: begin
                    // every latch goes out, written or not
                    flash_prog_we <= 1'b1;
                    flash_addr <= {row_base, word_idx, 1'b0};
                    flash_wdata <= latch[word_idx];
                    word_idx <= word_idx + 1'b1;
                    if (word_idx == IW'(ROW_WORDS - 1)) begin
                        state <= fsp_pkg::st_wait;
                    end
                end
                fsp_pkg::st_erase: begin
                    // one request for the aligned block
                    flash_erase_req <= 1'b1;
                    flash_addr <= {erase_row, {(IW + 1){1'b0}}};
                    state <= fsp_pkg::st_wait;
                end
                fsp_pkg::st_wait: begin
                    flash_prog_we <= 1'b0;
                    flash_erase_req <= 1'b0;
                    // array answered: release core, clear start
                    if (flash_done) begin
                        ctrl_start <= 1'b0;
                        cpu_stall <= 1'b0;
                        state <= fsp_pkg::st_idle;
                    end
                end
                default: begin
                    state <= fsp_pkg::st_idle;
                end
            endcase
        end
    end

    // count of consecutive row write strobes, read by checks only
    logic [7:0] we_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            we_run <= 8'h00;
        end else begin
            we_run <= flash_prog_we ? we_run + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // key pair then start
    sequence s_keyed_start;
        key_stage == fsp_pkg::key_armed && wr_ctrl && pwdata[`FSP_CTRL_START] && !busy;
    endsequence

    property p_keyed_launch;
        s_keyed_start |=> ctrl_start && cpu_stall && state != fsp_pkg::st_idle;
    endproperty
    a_keyed_launch: assert property (p_keyed_launch) else $error("keyed start did not launch");

    property p_keyless_ignored;
        (wr_ctrl && pwdata[`FSP_CTRL_START] && key_stage != fsp_pkg::key_armed && !busy)
            |=> state == fsp_pkg::st_idle && !ctrl_start && $stable(latch[0]);
    endproperty
    a_keyless_ignored: assert property (p_keyless_ignored) else $error("start without key acted");

    property p_start_held;
        busy |-> ctrl_start;
    endproperty
    a_start_held: assert property (p_start_held) else $error("start bit dropped while busy");

    property p_done_same_cycle;
        done_evt |=> !ctrl_start && flag && !cpu_stall && state == fsp_pkg::st_idle;
    endproperty
    a_done_same_cycle: assert property (p_done_same_cycle) else $error("flag and start not in step");

    property p_stall_blocks_bus;
        cpu_stall |-> !pready;
    endproperty
    a_stall_blocks_bus: assert property (p_stall_blocks_bus) else $error("bus answered during stall");

    property p_row_length;
        // the run counter already holds the full count when the strobe is seen low
        $fell(flash_prog_we) |-> we_run == 8'(ROW_WORDS);
    endproperty
    a_row_length: assert property (p_row_length) else $error("row stream length wrong");

    property p_erase_aligned;
        (flash_erase_req && flash_erase_size == `FSP_ERASE_4ROW) |-> flash_addr[IW+2:0] == '0;
    endproperty
    a_erase_aligned: assert property (p_erase_aligned) else $error("erase block misaligned");

    property p_latch_replace;
        wr_lat |=> latch[$past(lat_idx)] == $past(pwdata[23:0]);
    endproperty
    a_latch_replace: assert property (p_latch_replace) else $error("latch not replaced");

    sequence s_setup_idle;
        psel && !penable && !pready && !busy;
    endsequence

    property p_two_cycle_write;
        s_setup_idle |=> pready ##1 !pready;
    endproperty
    a_two_cycle_write: assert property (p_two_cycle_write) else $error("transfer not two cycles");

    property p_vis_page_legal;
        vis_page == `FSP_VIS_FLASH || vis_page == `FSP_VIS_EEPROM;
    endproperty
    a_vis_page_legal: assert property (p_vis_page_legal) else $error("visibility page illegal");

    property p_key_reads_zero;
        (s_setup_idle and (sel_key && !pwrite)) |=> prdata == 32'h00000000;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero) else $error("key register readable");

    property p_irq_follows;
        // a clear written in the same cycle drops the line at once
        (flag && mask && !wr_stat) |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

    // one erase request per operation
    property p_erase_one_pulse;
        flash_erase_req |=> !flash_erase_req;
    endproperty
    a_erase_one_pulse: assert property (p_erase_one_pulse) else $error("erase request held too long");

endmodule

// File: dv/fsp_flash_model.sv
`timescale 1ns/100ps

module fsp_flash_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flash_prog_we,
    input wire logic flash_erase_req,
    input wire logic [1:0] flash_erase_size,
    input wire logic [23:0] flash_addr,
    input wire logic [23:0] flash_wdata,
    input wire logic [7:0] done_delay,
    output logic flash_done
);
    logic [23:0] row_data [0:31]; // words of the last row programmed
    logic [23:0] first_addr; // first word address of the last burst
    logic [23:0] last_addr; // base address of the last erase
    logic [1:0] last_size; // size code of the last erase
    logic bad_row; // a burst strayed outside one row
    logic prev_we; // program strobe one cycle ago
    logic busy; // array working, done still owed
    logic [7:0] wait_cnt; // cycles left before done
    int we_count; // program strobes seen
    int erase_count; // erase pulses seen

    // array side: take words or erase, then answer done after the delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 32; i++) begin
                row_data[i] <= 24'h000000;
            end
            first_addr <= 24'h000000;
            last_addr <= 24'h000000;
            last_size <= 2'h0;
            bad_row <= 1'b0;
            prev_we <= 1'b0;
            busy <= 1'b0;
            wait_cnt <= 8'h00;
            we_count <= 0;
            erase_count <= 0;
            flash_done <= 1'b0;
        end else begin
            prev_we <= flash_prog_we;
            flash_done <= 1'b0;
            if (flash_prog_we) begin
                row_data[flash_addr[5:1]] <= flash_wdata;
                we_count <= we_count + 1;
                if (!prev_we) begin
                    first_addr <= flash_addr;
                end else if (flash_addr[23:6] != first_addr[23:6]) begin
                    bad_row <= 1'b1;
                end
            end
            if (flash_erase_req) begin
                last_addr <= flash_addr;
                last_size <= flash_erase_size;
                erase_count <= erase_count + 1;
            end
            // done owed once the stream ends or the erase is asked
            if ((prev_we && !flash_prog_we) || flash_erase_req) begin
                busy <= 1'b1;
                wait_cnt <= done_delay;
            end else if (busy) begin
                if (wait_cnt == 8'h00) begin
                    busy <= 1'b0;
                    flash_done <= 1'b1;
                end else begin
                    wait_cnt <= wait_cnt - 8'h01;
                end
            end
        end
    end
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
`include "fsp_defs.svh"

module testbench;
    logic pclk = 1'b0; // bus clock
    logic presetn = 1'b0; // async reset, active low
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] done_delay = 8'd20; // array answer time
    logic [31:0] prdata;
    logic pready, pslverr, irq, cpu_stall, prog_we, erase_req, mem_sel, done;
    logic [1:0] erase_size;
    logic [23:0] faddr, fwdata;
    logic [31:0] r; // last read data
    logic e; // last error response
    int miscompares = 0; // mismatches seen
    int checks_done = 0; // comparisons made

    always #25 pclk = ~pclk;

    fsp_ctrl #(.ROW_WORDS(32)) fsp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .cpu_stall(cpu_stall), .flash_prog_we(prog_we), .flash_erase_req(erase_req),
        .flash_erase_size(erase_size), .flash_mem_sel(mem_sel), .flash_addr(faddr), .flash_wdata(fwdata),
        .flash_done(done));

    fsp_flash_model fsp_flash_model_i (.pclk(pclk), .presetn(presetn), .flash_prog_we(prog_we),
        .flash_erase_req(erase_req), .flash_erase_size(erase_size), .flash_addr(faddr), .flash_wdata(fwdata),
        .done_delay(done_delay), .flash_done(done));

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one apb transfer; pready and read data are taken at the rising edge itself
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (!got) begin
            @(posedge pclk);
            got = (pready === 1'b1);
            r = prdata;
            e = pslverr;
            n++;
            if (n > 300) begin
                miscompares++;
                end_sim();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // read and compare the masked bits
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        check(r & m, exp);
    endtask

    task automatic unlock;
        wr(`FSP_OFF_KEY, 32'h55);
        wr(`FSP_OFF_KEY, 32'haa);
    endtask

    // erase base addresses for table pointer 0001c6, per size code
    logic [23:0] erase_base [0:2] = '{24'h0001c0, 24'h000180, 24'h000100};

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, key write only, unmapped place
        rd(`FSP_OFF_STATUS, 32'h0, 32'h8000);
        rd(`FSP_OFF_KEY, 32'h0, 32'hffffffff);
        rd(`FSP_OFF_LATCH, 32'hffffff, 32'hffffff);
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, e}, 32'h1);
        $display("test reset done");
        // latches out of order, rewritten
        wr(`FSP_OFF_TBLPAGE, 32'h01);
        wr(`FSP_OFF_TBLEA, 32'h46);
        wr(`FSP_OFF_LATCH, 32'h111111);
        wr(`FSP_OFF_LATCH, 32'h222222);
        wr(`FSP_OFF_TBLEA, 32'h40);
        wr(`FSP_OFF_LATCH, 32'h333333);
        wr(`FSP_OFF_TBLEA, 32'h46);
        rd(`FSP_OFF_LATCH, 32'h222222, 32'hffffff);
        // start without key, then key broken by another write
        wr(`FSP_OFF_CTRL, 32'h8051);
        rd(`FSP_OFF_CTRL, 32'h0051, 32'h8053);
        wr(`FSP_OFF_KEY, 32'h55);
        wr(`FSP_OFF_TBLEA, 32'h46);
        wr(`FSP_OFF_KEY, 32'haa);
        wr(`FSP_OFF_CTRL, 32'h8010);
        rd(`FSP_OFF_CTRL, 32'h0010, 32'h8053);
        check(32'(fsp_flash_model_i.we_count), 32'd0);
        rd(`FSP_OFF_LATCH, 32'h222222, 32'hffffff);
        $display("test refused start done");
        // row program with slow array
        unlock();
        wr(`FSP_OFF_CTRL, 32'h8050);
        check({31'h0, cpu_stall}, 32'h1);
        check({31'h0, mem_sel}, 32'h1);
        rd(`FSP_OFF_STATUS, 32'h8000, 32'h8000);
        rd(`FSP_OFF_CTRL, 32'h0050, 32'h8053);
        check({31'h0, cpu_stall}, 32'h0);
        check(32'(fsp_flash_model_i.we_count), 32'd32);
        check(32'(fsp_flash_model_i.bad_row), 32'h0);
        check(32'(fsp_flash_model_i.first_addr), 32'h010040);
        check(32'(fsp_flash_model_i.row_data[0]), 32'h333333);
        check(32'(fsp_flash_model_i.row_data[3]), 32'h222222);
        check(32'(fsp_flash_model_i.row_data[5]), 32'hffffff);
        $display("test program done");
        // interrupt enabled by the mask, raised, cleared
        wr(`FSP_OFF_MASK, 32'h8000);
        @(negedge pclk);
        check({31'h0, irq}, 32'h1);
        wr(`FSP_OFF_STATUS, 32'h8000);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0);
        rd(`FSP_OFF_STATUS, 32'h0, 32'h8000);
        $display("test interrupt done");
        // every erase size, prompt array, unaligned pointer
        done_delay <= 8'd0;
        wr(`FSP_OFF_TBLPAGE, 32'h00);
        wr(`FSP_OFF_TBLEA, 32'h1c6);
        for (int s = 0; s < 3; s++) begin
            unlock();
            wr(`FSP_OFF_CTRL, 32'h8000 | s);
            rd(`FSP_OFF_STATUS, 32'h8000, 32'h8000);
            check(32'(fsp_flash_model_i.last_addr), 32'(erase_base[s]));
            check(32'(fsp_flash_model_i.last_size), 32'(s));
            wr(`FSP_OFF_STATUS, 32'h8000);
        end
        check(32'(fsp_flash_model_i.erase_count), 32'd3);
        $display("test erase done");
        // visibility window mapping
        wr(`FSP_OFF_VISPAGE, 32'hff);
        wr(`FSP_OFF_VISEA, 32'h8123);
        rd(`FSP_OFF_VISADDR, 32'h7f8123, 32'hffffff);
        wr(`FSP_OFF_VISPAGE, 32'h12);
        rd(`FSP_OFF_VISPAGE, 32'hff, 32'hff);
        wr(`FSP_OFF_VISPAGE, 32'h00);
        rd(`FSP_OFF_VISADDR, 32'h000123, 32'hffffff);
        $display("test visibility done");
        end_sim();
    end
endmodule
